/* File: inc/freq_pull_pkg.sv */
package freq_pull_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int WORD_W = 26;
    localparam int LOW_W  = 16;
    localparam int HIGH_W = 10;
    localparam int CODE_W = 4;
    localparam int SPAN_W = 14;
    localparam int RES_W  = 7;

    // ****************************************************************
    // register offsets, field positions, reset values
    // ****************************************************************
    localparam logic [ADDR_W-1:0] FREQ_LOW_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] DRIVE_HIGH_OFS = 8'h01;
    localparam logic [ADDR_W-1:0] PULL_SPAN_OFS  = 8'h02;
    localparam int                HIGH_LSB       = 0;
    localparam int                OE_BIT         = 10;
    localparam int                CODE_LSB       = 0;
    localparam logic [LOW_W-1:0]  FREQ_LOW_RST   = 16'h0000;
    localparam logic [HIGH_W-1:0] FREQ_HIGH_RST  = 10'h000;
    localparam logic              DRIVE_OE_RST   = 1'b0;
    localparam logic [CODE_W-1:0] PULL_CODE_RST  = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO      = 16'h0000;

    // ****************************************************************
    // offset word limits
    // ****************************************************************
    localparam logic [WORD_W-1:0] WORD_RST      = 26'h0000000;
    localparam logic [WORD_W-1:0] WORD_NEG_FULL = 26'h2000000;
    localparam logic [WORD_W-1:0] WORD_NEG_LIM  = 26'h2000001;

    // ****************************************************************
    // half pull span per code, in quarter ppm, code 0 narrowest
    // ****************************************************************
    localparam logic [15:0][SPAN_W-1:0] SPAN_TABLE = {
        14'h3200, 14'h1900, 14'h12C0, 14'h0C80,
        14'h0960, 14'h0640, 14'h0320, 14'h0258,
        14'h01F4, 14'h0190, 14'h0140, 14'h00C8,
        14'h0064, 14'h0032, 14'h0028, 14'h0019};

    // step of one count, in units of 1e-12
    localparam logic [15:0][RES_W-1:0] RES_TABLE = {
        7'h5E, 7'h2F, 7'h20, 7'h15, 7'h0E, 7'h0A, 7'h05, 7'h05,
        7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05};

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } ctrl_state_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic [SPAN_W-1:0] span;
        logic [RES_W-1:0]  res;
    } pull_cfg_t;

endpackage

/* File: rtl/freq_pull_limiter.sv */
`timescale 1ns/1ps
`default_nettype none

module freq_pull_limiter
    import freq_pull_pkg::*;
(
    // request
    input  wire logic [freq_pull_pkg::WORD_W-1:0] word_in,
    input  wire logic [freq_pull_pkg::CODE_W-1:0] code,
    // result
    output logic      [freq_pull_pkg::WORD_W-1:0] word_out,
    output logic      [freq_pull_pkg::SPAN_W-1:0] span,
    output logic      [freq_pull_pkg::RES_W-1:0]  res
);

    // ****************************************************************
    // saturation and table lookup
    // ****************************************************************

    // full negative scale would overshoot the span by one count
    always_comb begin
        if (word_in == WORD_NEG_FULL) begin
            word_out = WORD_NEG_LIM;
        end else begin
            word_out = word_in;
        end
    end

    // codes ascend in width; step grows only for the wide spans
    always_comb begin
        span = SPAN_TABLE[code];
        res  = RES_TABLE[code];
    end

endmodule

`default_nettype wire

/* File: rtl/freq_pull_control_regs.sv */
// Overview of operation
// - power-up uses nominal frequency, factory pull span
// - accepts writes to pull span and offset
// - commanded deviation clamped to selected span
// - four-bit code picks one of sixteen spans
// - offset word is 26-bit two's complement
// - offset word resets to zero
// - low bits at 0x00, high bits 0x01[9:0]
// - offset applied only on high word write
// - drive bit acts only under software mode
// - count step depends on selected span
// - drive bit zero disables, one enables driver
// - unused high-register bits read zero
`timescale 1ns/1ps
`default_nettype none

module freq_pull_control_regs (
    // clock, reset, enable
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // decoded register access
    input  wire freq_pull_pkg::reg_req_t     req,
    output logic [freq_pull_pkg::DATA_W-1:0] rdata,
    // factory straps and pin
    input  wire logic [freq_pull_pkg::CODE_W-1:0] factory_pull_code,
    input  wire logic                        sw_oe_mode,
    input  wire logic                        oe_pin,
    // to the pulling loop and driver
    output freq_pull_pkg::pull_cfg_t         cfg,
    output logic                             update_pulse,
    output logic                             drive_enable
);
    import freq_pull_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
        is_reg = (a == ofs);
    endfunction

    ctrl_state_t       state_reg;
    logic [LOW_W-1:0]  low_reg;
    logic [HIGH_W-1:0] high_reg;
    logic              oe_reg;
    logic              sw_mode_reg;
    logic [CODE_W-1:0] code_reg;
    logic [WORD_W-1:0] word_next;
    logic [SPAN_W-1:0] span_next;
    logic [RES_W-1:0]  res_next;
    logic              run;
    logic              wr_low;
    logic              wr_high;
    logic              wr_pull;

    assign run     = (state_reg == ST_RUN);
    assign wr_low  = run && req.wr && is_reg(req.addr, FREQ_LOW_OFS);
    assign wr_high = run && req.wr && is_reg(req.addr, DRIVE_HIGH_OFS);
    assign wr_pull = run && req.wr && is_reg(req.addr, PULL_SPAN_OFS);

    // ****************************************************************
    // strap capture
    // ****************************************************************

    // straps are sampled one cycle after release, not under reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_STRAP;
        end else if (ce) begin
            case (state_reg)
                ST_STRAP: state_reg <= ST_RUN;
                ST_RUN:   state_reg <= ST_RUN;
                default:  state_reg <= ST_STRAP;
            endcase
        end
    end

    // output-enable mode is fixed by configuration
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sw_mode_reg <= 1'b0;
        end else if (ce && !run) begin
            sw_mode_reg <= sw_oe_mode;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // low word only stages the value
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            low_reg <= FREQ_LOW_RST;
        end else if (ce && wr_low) begin
            low_reg <= req.wdata[LOW_W-1:0];
        end
    end

    // bits 15:11 are never stored, so they read zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            high_reg <= FREQ_HIGH_RST;
        end else if (ce && wr_high) begin
            high_reg <= req.wdata[HIGH_LSB +: HIGH_W];
        end
    end

    // under pin control the write is dropped
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oe_reg <= DRIVE_OE_RST;
        end else if (ce && wr_high && sw_mode_reg) begin
            oe_reg <= req.wdata[OE_BIT];
        end
    end

    // factory span first, software may replace it later
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            code_reg <= PULL_CODE_RST;
        end else if (ce && !run) begin
            code_reg <= factory_pull_code;
        end else if (ce && wr_pull) begin
            code_reg <= req.wdata[CODE_LSB +: CODE_W];
        end
    end

    // ****************************************************************
    // offset word and span
    // ****************************************************************
    freq_pull_limiter u_limiter (
        .word_in  ({req.wdata[HIGH_LSB +: HIGH_W], low_reg}),
        .code     (code_reg),
        .word_out (word_next),
        .span     (span_next),
        .res      (res_next)
    );

    // signed word committed as a whole, so no half-written word is seen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg.word <= WORD_RST;
        end else if (ce && wr_high) begin
            cfg.word <= word_next;
        end
    end

    // span follows the code one cycle later
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg.span <= SPAN_TABLE[PULL_CODE_RST];
            cfg.res  <= RES_TABLE[PULL_CODE_RST];
        end else if (ce) begin
            cfg.span <= span_next;
            cfg.res  <= res_next;
        end
    end

    // one-cycle strobe when a new offset takes effect
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            update_pulse <= 1'b0;
        end else if (ce) begin
            update_pulse <= wr_high;
        end
    end

    // ****************************************************************
    // driver and readback
    // ****************************************************************

    // pin path is sampled too, so the output is always a flop
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            drive_enable <= 1'b0;
        end else if (ce) begin
            drive_enable <= sw_mode_reg ? oe_reg : oe_pin;
        end
    end

    // unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= READ_ZERO;
        end else if (ce && req.rd) begin
            if (is_reg(req.addr, FREQ_LOW_OFS)) begin
                rdata <= low_reg;
            end else if (is_reg(req.addr, DRIVE_HIGH_OFS)) begin
                rdata <= {5'h00, oe_reg, high_reg};
            end else if (is_reg(req.addr, PULL_SPAN_OFS)) begin
                rdata <= {12'h000, code_reg};
            end else begin
                rdata <= READ_ZERO;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_low_no_apply;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && wr_low && !wr_high) |=> $stable(cfg.word);
    endproperty
    a_low_no_apply: assert property (p_low_no_apply)
        else $error("low word write changed offset");

    property p_high_apply;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && wr_high) |=> (cfg.word == $past(word_next)) && update_pulse;
    endproperty
    a_high_apply: assert property (p_high_apply)
        else $error("high word write did not apply offset");

    property p_clamp;
        @(posedge sys_clk) disable iff (!resetn)
        cfg.word != WORD_NEG_FULL;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("offset beyond pull span");

    property p_zero_at_start;
        @(posedge sys_clk) disable iff (!resetn)
        !run |-> (cfg.word == WORD_RST) && !update_pulse;
    endproperty
    a_zero_at_start: assert property (p_zero_at_start)
        else $error("offset not zero after reset");

    property p_strap;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && !run) |=> (code_reg == $past(factory_pull_code));
    endproperty
    a_strap: assert property (p_strap)
        else $error("factory span not taken");

    property p_pull_write;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && wr_pull) |=> (code_reg == $past(req.wdata[3:0]));
    endproperty
    a_pull_write: assert property (p_pull_write)
        else $error("pull span write lost");

    property p_pin_oe;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && run && !sw_mode_reg) |=> (drive_enable == $past(oe_pin)) && $stable(oe_reg);
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("pin control not followed");

    property p_sw_oe;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && sw_mode_reg && wr_high) |=> ce [*1] |=> (drive_enable == $past(req.wdata[10], 2));
    endproperty
    a_sw_oe: assert property (p_sw_oe)
        else $error("software drive bit not followed");

    property p_unused_read;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && req.rd && !is_reg(req.addr, FREQ_LOW_OFS)) |=> (rdata[15:11] == 5'h00);
    endproperty
    a_unused_read: assert property (p_unused_read)
        else $error("unused high bits not zero");

    property p_span;
        @(posedge sys_clk) disable iff (!resetn)
        (ce && code_reg <= 4'h9) |=> (cfg.res == 7'h05) && (cfg.span <= 14'h0320);
    endproperty
    a_span: assert property (p_span)
        else $error("span or step wrong for narrow code");

    c_apply:     cover property (@(posedge sys_clk) disable iff (!resetn)
        ce && wr_low ##[1:4] ce && wr_high);
    c_neg_clamp: cover property (@(posedge sys_clk) disable iff (!resetn)
        wr_high && word_next == WORD_NEG_LIM);
    c_widest:    cover property (@(posedge sys_clk) disable iff (!resetn) cfg.span == 14'h3200);
    c_sw_on:     cover property (@(posedge sys_clk) disable iff (!resetn) sw_mode_reg && $rose(drive_enable));

endmodule

`default_nettype wire

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host side of the register port, paced like a real controller
module host_model
    import freq_pull_pkg::*;
#(
    parameter int MIN_GAP = 3290 // 125 MHz clock over a 38 kHz update rate
) (
    // clock
    input  wire logic                             sys_clk,
    // register access
    output freq_pull_pkg::reg_req_t               req,
    input  wire logic [freq_pull_pkg::DATA_W-1:0] rdata
);
    // ****************************************************************
    // pacing and bus cycles
    // ****************************************************************
    int gap = MIN_GAP;

    initial req = '0;

    // cycles since the last offset commit
    always @(posedge sys_clk) gap <= gap + 1;

    // one write, held across its taking edge, then the bus scrambled;
    // every high word write is an offset update, so it is paced
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        if (a == DRIVE_HIGH_OFS)
            wait (gap >= MIN_GAP);
        @(negedge sys_clk);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req.wr    = 1'b0;
        req.addr  = ~a;  // released lines never keep the last value
        req.wdata = ~d;
        if (a == DRIVE_HIGH_OFS)
            gap = 0;
    endtask

    // one read, data taken in the cycle after the request
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        req.rd   = 1'b1;
        req.addr = a;
        @(posedge sys_clk);
        @(negedge sys_clk);
        d        = rdata;
        req.rd   = 1'b0;
        req.addr = ~a;
    endtask

    // signed offset scaled to the half span, rounded to nearest
    function automatic logic [25:0] ppm_word(input longint num, input longint den);
        longint v;
        v = 64'sd67108862 * num;
        if (v >= 0)
            return 26'((v + den) / (2 * den));
        return 26'(-((-v + den) / (2 * den)));
    endfunction

    // low word first, then high word with the drive bit
    task automatic set_word(input logic [25:0] w, input logic oe);
        write_reg(8'h00, w[15:0]);
        write_reg(8'h01, {5'h00, oe, w[25:16]});
    endtask

    task automatic set_offset(input longint num, input longint den, input logic oe);
        set_word(ppm_word(num, den), oe);
    endtask
endmodule

`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    import freq_pull_pkg::*;

    // ****************************************************************
    // signals and expectations
    // ****************************************************************
    logic              sys_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              ce = 1'b1;
    reg_req_t          req;
    logic [DATA_W-1:0] rdata;
    logic [CODE_W-1:0] factory_pull_code = 4'h0;
    logic              sw_oe_mode = 1'b1;
    logic              oe_pin = 1'b0;
    pull_cfg_t         cfg;
    logic              update_pulse;
    logic              drive_enable;
    int                n_errors = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                pulses = 0;
    logic              last_pulse = 1'b0;
    logic [15:0]       rd;
    // half span in quarter ppm and step in 1e-12, narrowest first
    localparam logic [13:0] SPAN_Q [16] = '{14'h0019, 14'h0028, 14'h0032, 14'h0064,
        14'h00C8, 14'h0140, 14'h0190, 14'h01F4, 14'h0258, 14'h0320, 14'h0640,
        14'h0960, 14'h0C80, 14'h12C0, 14'h1900, 14'h3200};
    localparam logic [6:0] RES_Q [16] = '{7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05,
        7'h05, 7'h05, 7'h05, 7'h05, 7'h0A, 7'h0E, 7'h15, 7'h20, 7'h2F, 7'h5E};

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    freq_pull_control_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req(req),
        .rdata(rdata), .factory_pull_code(factory_pull_code), .sw_oe_mode(sw_oe_mode),
        .oe_pin(oe_pin), .cfg(cfg), .update_pulse(update_pulse), .drive_enable(drive_enable));

    host_model u_host (.sys_clk(sys_clk), .req(req), .rdata(rdata));

    // pulse counting, width check and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (update_pulse === 1'b1 && !last_pulse)
            pulses++;
        if (update_pulse === 1'b1 && last_pulse)
            `CHK("pulse_width", 1'b0, 1'b1)
        last_pulse <= (update_pulse === 1'b1);
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic do_reset(input logic [3:0] code, input logic sw);
        @(negedge sys_clk);
        resetn = 1'b0;
        factory_pull_code = code;
        sw_oe_mode = sw;
        repeat (2) @(negedge sys_clk);
        `CHK("rst_word", 26'h0000000, cfg.word)
        `CHK("rst_span", 14'h0019, cfg.span)
        `CHK("rst_drive", 1'b0, drive_enable)
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK("strap_span", SPAN_Q[code], cfg.span)
        `CHK("strap_word", 26'h0000000, cfg.word)
    endtask

    task automatic t_offset();
        int p;
        p = pulses;
        u_host.write_reg(8'h00, 16'h1234);
        repeat (4) @(negedge sys_clk);
        `CHK("low_only_pulse", p, pulses)
        `CHK("low_only_word", 26'h0000000, cfg.word)
        u_host.set_offset(90, 200, 1'b1);
        repeat (2) @(negedge sys_clk);
        `CHK("pos_word", 26'h0E66666, cfg.word)
        `CHK("pos_pulse", p + 1, pulses)
        `CHK("sw_drive_on", 1'b1, drive_enable)
        u_host.set_offset(-50, 200, 1'b1);
        repeat (2) @(negedge sys_clk);
        `CHK("neg_word", 26'h3800000, cfg.word)
        u_host.set_word(26'h2000000, 1'b0);
        repeat (2) @(negedge sys_clk);
        `CHK("clamp_word", 26'h2000001, cfg.word)
        `CHK("sw_drive_off", 1'b0, drive_enable)
    endtask

    task automatic t_regs();
        u_host.write_reg(8'h01, 16'hFFFF);
        u_host.read_reg(8'h01, rd);
        `CHK("high_read", 16'h07FF, rd)
        u_host.write_reg(8'h00, 16'hA5C3);
        u_host.read_reg(8'h00, rd);
        `CHK("low_read", 16'hA5C3, rd)
        u_host.write_reg(8'h02, 16'hFFFF);
        u_host.read_reg(8'h02, rd);
        `CHK("span_read", 16'h000F, rd)
        u_host.write_reg(8'h05, 16'hFFFF);
        u_host.read_reg(8'h05, rd);
        `CHK("unmapped_read", 16'h0000, rd)
    endtask

    task automatic t_span();
        for (int i = 0; i < 16; i++) begin
            u_host.write_reg(8'h02, 16'(i));
            repeat (2) @(negedge sys_clk);
            `CHK("span", SPAN_Q[i], cfg.span)
            `CHK("step", RES_Q[i], cfg.res)
        end
        // clock enable low: a span write must not land
        ce = 1'b0;
        u_host.write_reg(8'h02, 16'h0000);
        repeat (2) @(negedge sys_clk);
        `CHK("freeze_span", SPAN_Q[15], cfg.span)
        ce = 1'b1;
    endtask

    // pin mode: the register bit must not reach the driver
    task automatic t_pin();
        do_reset(4'h9, 1'b0);
        oe_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK("pin_on", 1'b1, drive_enable)
        oe_pin = 1'b0;
        u_host.write_reg(8'h01, 16'h0400);
        repeat (3) @(negedge sys_clk);
        `CHK("pin_off", 1'b0, drive_enable)
        u_host.read_reg(8'h01, rd);
        `CHK("pin_bit_read", 16'h0000, rd)
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        do_reset(4'h3, 1'b1);
        t_offset();
        t_regs();
        t_span();
        t_pin();
        tally_and_finish();
    end
endmodule

`default_nettype wire
